//--- shared/routing_pkg.sv
/*
 * routing_pkg: constants for the routing matrix with pin-mode decode.
 * assumes a 2048-bit configuration image and a 32-bit classic wishbone slave.
 */
package routing_pkg;
	localparam int CFG_BITS = 2048;
	localparam int N_SRC = 64;
	localparam int N_DST = 110;
	localparam int SLOT_W = 8;
	localparam int SEL_W = 6;
	localparam int N_PIN = 16;
	localparam int WORD_W = 32;
	localparam int CFG_WORD_AW = 6;
	// wishbone byte addresses
	localparam logic [7:0] ADR_VIRT = 8'h00;
	localparam logic [7:0] ADR_CFG_ADDR = 8'h04;
	localparam logic [7:0] ADR_CFG_DATA = 8'h08;
	localparam logic [7:0] ADR_RELOAD = 8'h0C;
	localparam logic [7:0] ADR_STATUS = 8'h10;
	// configuration bit positions
	localparam int SEL_IO6_BIT = 1074;
	localparam int SEL_IO7_BIT = 1082;
	localparam int VIRT_LSB = 1952;
	localparam int PREDIV_LSB = 1960;
	localparam int PSW_OUT0_IDX = 48;
	localparam int PSW_OUT1_IDX = 50;
	// pin structure kinds
	localparam logic [5:0] KIND_GPI = 6'h01;
	localparam logic [5:0] KIND_MOE = 6'h02;
	localparam logic [5:0] KIND_SER = 6'h04;
	localparam logic [5:0] KIND_MOE4 = 6'h08;
	localparam logic [5:0] KIND_REG = 6'h10;
	localparam logic [5:0] KIND_REG4 = 6'h20;
	localparam logic [5:0] PIN_KIND [N_PIN] = '{KIND_GPI, KIND_MOE, KIND_REG, KIND_MOE, KIND_REG, KIND_MOE,
		KIND_SER, KIND_SER, KIND_MOE4, KIND_REG4, KIND_MOE, KIND_MOE, KIND_REG, KIND_MOE, KIND_REG, KIND_MOE};
	localparam int PIN_MODE_LSB [N_PIN] = '{1032, 1034, 1040, 1044, 1061, 1068, 1077, 1085, 1092, 1101, 1108,
		1116, 1125, 1132, 1141, 1148};
	localparam int PIN_OMODE_LSB [N_PIN] = '{1032, 1036, 1040, 1046, 1061, 1070, 1077, 1085, 1094, 1101, 1110,
		1118, 1125, 1134, 1141, 1150};
	localparam int PIN_DOUT_IDX [N_PIN] = '{0, 25, 27, 28, 30, 31, 33, 34, 35, 37, 38, 40, 42, 43, 45, 46};
	localparam int PIN_OE_IDX [N_PIN] = '{0, 26, 0, 29, 0, 32, 0, 0, 36, 0, 39, 41, 0, 44, 0, 47};
	// enable vector layout
	localparam int EN_W = 12;
	localparam int EN_PLAIN = 0;
	localparam int EN_HYST = 1;
	localparam int EN_LV = 2;
	localparam int EN_ANA = 3;
	localparam int EN_PP1 = 4;
	localparam int EN_PP2 = 5;
	localparam int EN_OD1 = 6;
	localparam int EN_OD2 = 7;
	localparam int EN_PP = 8;
	localparam int EN_ODN = 9;
	localparam int EN_ODP = 10;
	localparam int EN_OE = 11;
	// mode codes
	localparam logic [1:0] M2_PLAIN = 2'h0;
	localparam logic [1:0] M2_HYST = 2'h1;
	localparam logic [1:0] M2_LV = 2'h2;
	localparam logic [1:0] M2_HIGH = 2'h3;
	localparam logic [2:0] M3_PLAIN = 3'h0;
	localparam logic [2:0] M3_HYST = 3'h1;
	localparam logic [2:0] M3_LV = 3'h2;
	localparam logic [2:0] M3_ANA = 3'h3;
	localparam logic [2:0] M3_PP = 3'h4;
	localparam logic [2:0] M3_ODN = 3'h5;
	localparam logic [2:0] M3_ODP = 3'h6;
	localparam logic [2:0] M3_ANA_ODN = 3'h7;
endpackage : routing_pkg

//--- src/routing_matrix.sv
/*
 * routing_matrix: 64-source, 110-destination connection matrix with pin-mode decode
 * and a classic wishbone slave for the configuration image and virtual inputs.
 * assumes the one-time image is stable at otp_image_i while rst_i is high and on reload.
 */
//
// Behaviour
// - input-only pin: decode input mode, oe zero
// - matrix-oe pins: code 11 is analog
// - output mode: push-pull or open-drain legs
// - matrix-oe pins: value, oe from matrix
// - quad-drive pin: open-drain modes add nmos enable
// - register pins: inputs force oe 0, 011 analog
// - register pins: drive codes force oe 1
// - register pins: 111 is nmos plus analog
// - register pins: oe from mode only
// - quad register pin decodes like register pins
// - matrix has 64 sources, 110 destinations
// - each destination picks source by 6-bit selector
// - sources fixed; 0 low, 63 high
// - source 62 is core power-on reset
// - sources 32,33 pin or virtual bit
// - sources 34-39 are virtual bits 2-7
// - source 29 is predivided fast oscillator
// - sources 24-26 are shift-delay stages
// - sources 55,56 are power switch pins
// - source 61 is delay with edge detect
// - configuration loaded from one-time image
// - 8-bit slot per destination, low six used
// - virtual byte writable, reads back current value
`timescale 1ns/1ps
module routing_matrix (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [routing_pkg::CFG_BITS-1:0] otp_image_i,
	input wire logic [routing_pkg::N_PIN-1:0] pin_in_i,
	input wire logic [1:0] power_switch_i,
	input wire logic [15:0] macro_out_i,
	input wire logic [2:0] pipe_stage_i,
	input wire logic [1:0] slow_osc_i,
	input wire logic osc_fast_i,
	input wire logic [1:0] filter_edge_i,
	input wire logic [7:0] asm_out_i,
	input wire logic [3:0] comparator_i,
	input wire logic delay_edge_i,
	input wire logic core_power_on_reset_n,
	output logic [routing_pkg::N_DST-1:0] matrix_o,
	output logic [routing_pkg::N_PIN-1:0] pin_out_o,
	output logic [routing_pkg::N_PIN-1:0] pin_oe_o,
	output logic [routing_pkg::N_PIN-1:0] plain_input_enable_o,
	output logic [routing_pkg::N_PIN-1:0] hysteresis_input_enable_o,
	output logic [routing_pkg::N_PIN-1:0] low_voltage_input_enable_o,
	output logic [routing_pkg::N_PIN-1:0] analog_path_enable_o,
	output logic [routing_pkg::N_PIN-1:0] push_pull_single_enable_o,
	output logic [routing_pkg::N_PIN-1:0] push_pull_double_enable_o,
	output logic [routing_pkg::N_PIN-1:0] open_drain_single_enable_o,
	output logic [routing_pkg::N_PIN-1:0] open_drain_double_enable_o,
	output logic [routing_pkg::N_PIN-1:0] push_pull_enable_o,
	output logic [routing_pkg::N_PIN-1:0] open_drain_nmos_enable_o,
	output logic [routing_pkg::N_PIN-1:0] open_drain_pmos_enable_o,
	output logic [1:0] power_switch_control_o
);
	import routing_pkg::*;

	logic [CFG_BITS-1:0] cfg_r;
	logic [7:0] virt_r;
	logic [CFG_WORD_AW-1:0] cfg_word_r;
	logic ack_r;
	logic [31:0] dat_r;
	logic [2:0] pre_cnt_r;
	logic osc_q_r;
	logic osc_div;
	logic src32;
	logic src33;
	logic [N_SRC-1:0] src_w;
	logic req;
	logic wr_en;
	logic reload;

	function automatic logic [EN_W-1:0] in_dec(input logic [1:0] m, input logic analog_ok);
		logic [EN_W-1:0] e;
		e = '0;
		case (m)
			M2_PLAIN: e[EN_PLAIN] = 1'b1;
			M2_HYST: e[EN_HYST] = 1'b1;
			M2_LV: e[EN_LV] = 1'b1;
			default: e[EN_ANA] = analog_ok;
		endcase
		return e;
	endfunction : in_dec

	function automatic logic [EN_W-1:0] out_dec(input logic [1:0] m, input logic nmos_too);
		logic [EN_W-1:0] e;
		e = '0;
		e[EN_OE] = 1'b1;
		case (m)
			M2_PLAIN: e[EN_PP1] = 1'b1;
			M2_HYST: begin
				e[EN_PP1] = 1'b1;
				e[EN_PP2] = 1'b1;
			end
			M2_LV: begin
				e[EN_OD1] = 1'b1;
				e[EN_ODN] = nmos_too;
			end
			default: begin
				e[EN_OD1] = 1'b1;
				e[EN_OD2] = 1'b1;
				e[EN_ODN] = nmos_too;
			end
		endcase
		return e;
	endfunction : out_dec

	// oe here is a pure function of the code; no matrix signal enters
	function automatic logic [EN_W-1:0] reg_dec(input logic [2:0] m);
		logic [EN_W-1:0] e;
		e = '0;
		case (m)
			M3_PLAIN: e[EN_PLAIN] = 1'b1;
			M3_HYST: e[EN_HYST] = 1'b1;
			M3_LV: e[EN_LV] = 1'b1;
			M3_ANA: e[EN_ANA] = 1'b1;
			M3_PP: begin
				e[EN_PP] = 1'b1;
				e[EN_OE] = 1'b1;
			end
			M3_ODN: begin
				e[EN_ODN] = 1'b1;
				e[EN_OE] = 1'b1;
			end
			M3_ODP: begin
				e[EN_ODP] = 1'b1;
				e[EN_OE] = 1'b1;
			end
			default: begin
				e[EN_ODN] = 1'b1;
				e[EN_ANA] = 1'b1;
				e[EN_OE] = 1'b1;
			end
		endcase
		return e;
	endfunction : reg_dec

	// reserved codes leave every leg off, so the pin floats
	function automatic logic [EN_W-1:0] ser_dec(input logic [2:0] m);
		logic [EN_W-1:0] e;
		e = '0;
		case (m)
			M3_PLAIN: e[EN_PLAIN] = 1'b1;
			M3_HYST: e[EN_HYST] = 1'b1;
			M3_LV: e[EN_LV] = 1'b1;
			M3_ODN: begin
				e[EN_ODN] = 1'b1;
				e[EN_OE] = 1'b1;
			end
			default: e = '0;
		endcase
		return e;
	endfunction : ser_dec

	// wishbone slave: ack one cycle after the request, dropped the cycle after
	assign req = cyc_i & stb_i & ~ack_r;
	assign wr_en = req & we_i;
	assign reload = wr_en && adr_i == ADR_RELOAD && sel_i[0] && dat_i[0];
	assign ack_o = ack_r;
	assign dat_o = dat_r;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= req;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= '0;
		end else if (req && !we_i) begin
			if (adr_i == ADR_VIRT)
				dat_r <= {24'h000000, virt_r};
			else if (adr_i == ADR_CFG_ADDR)
				dat_r <= {26'h0000000, cfg_word_r};
			else if (adr_i == ADR_CFG_DATA)
				dat_r <= cfg_r[cfg_word_r*WORD_W +: WORD_W];
			else if (adr_i == ADR_STATUS)
				dat_r <= {pin_in_i, pin_oe_o};
			else
				dat_r <= '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			cfg_word_r <= '0;
		else if (wr_en && adr_i == ADR_CFG_ADDR && sel_i[0])
			cfg_word_r <= dat_i[CFG_WORD_AW-1:0];
	end

	// image taken at reset and on reload; single words may be patched afterwards
	always_ff @(posedge clk_i) begin
		if (rst_i || reload) begin
			cfg_r <= otp_image_i;
		end else if (wr_en && adr_i == ADR_CFG_DATA) begin
			for (int b = 0; b < 4; b++) begin
				if (sel_i[b])
					cfg_r[cfg_word_r*WORD_W + b*8 +: 8] <= dat_i[b*8 +: 8];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || reload)
			virt_r <= otp_image_i[VIRT_LSB +: 8];
		else if (wr_en && adr_i == ADR_VIRT && sel_i[0])
			virt_r <= dat_i[7:0];
	end

	// fast oscillator predivider: count rising edges of the sampled oscillator
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_q_r <= 1'b0;
			pre_cnt_r <= '0;
		end else begin
			osc_q_r <= osc_fast_i;
			if (osc_fast_i && !osc_q_r)
				pre_cnt_r <= pre_cnt_r + 3'h1;
		end
	end

	always_comb begin
		case (cfg_r[PREDIV_LSB +: 2])
			2'h0: osc_div = osc_fast_i;
			2'h1: osc_div = pre_cnt_r[0];
			2'h2: osc_div = pre_cnt_r[1];
			default: osc_div = pre_cnt_r[2];
		endcase
	end

	assign src32 = cfg_r[SEL_IO6_BIT] ? pin_in_i[6] : virt_r[0];
	assign src33 = cfg_r[SEL_IO7_BIT] ? pin_in_i[7] : virt_r[1];

	// fixed wiring of the 64 sources, high index first
	assign src_w = {1'b1, core_power_on_reset_n, delay_edge_i, comparator_i, power_switch_i,
		pin_in_i[15:9], asm_out_i, virt_r[7:2], src33, src32, filter_edge_i, osc_div,
		slow_osc_i, pipe_stage_i, macro_out_i, pin_in_i[8], pin_in_i[5:0], 1'b0};

	// destinations are pure muxes so they track the source with no added latency
	generate
		for (genvar d = 0; d < N_DST; d++) begin : g_dst
			assign matrix_o[d] = src_w[cfg_r[d*SLOT_W +: SEL_W]];
		end
	endgenerate

	assign power_switch_control_o = {matrix_o[PSW_OUT1_IDX], matrix_o[PSW_OUT0_IDX]};

	generate
		for (genvar g = 0; g < N_PIN; g++) begin : g_pin
			logic [EN_W-1:0] en;
			logic [2:0] m3;
			logic [1:0] mi;
			logic [1:0] mo;
			logic moe;
			assign m3 = cfg_r[PIN_MODE_LSB[g] +: 3];
			assign mi = cfg_r[PIN_MODE_LSB[g] +: 2];
			assign mo = cfg_r[PIN_OMODE_LSB[g] +: 2];
			assign moe = matrix_o[PIN_OE_IDX[g]];
			always_comb begin
				case (PIN_KIND[g])
					KIND_GPI: en = in_dec(mi, 1'b0);
					KIND_MOE: en = moe ? out_dec(mo, 1'b0) : in_dec(mi, 1'b1);
					KIND_MOE4: en = moe ? out_dec(mo, 1'b1) : in_dec(mi, 1'b1);
					KIND_SER: en = ser_dec(m3);
					default: en = reg_dec(m3);
				endcase
			end
			assign pin_out_o[g] = (PIN_KIND[g] == KIND_GPI) ? 1'b0 : matrix_o[PIN_DOUT_IDX[g]];
			assign pin_oe_o[g] = en[EN_OE];
			assign plain_input_enable_o[g] = en[EN_PLAIN];
			assign hysteresis_input_enable_o[g] = en[EN_HYST];
			assign low_voltage_input_enable_o[g] = en[EN_LV];
			assign analog_path_enable_o[g] = en[EN_ANA];
			assign push_pull_single_enable_o[g] = en[EN_PP1];
			assign push_pull_double_enable_o[g] = en[EN_PP2];
			assign open_drain_single_enable_o[g] = en[EN_OD1];
			assign open_drain_double_enable_o[g] = en[EN_OD2];
			assign push_pull_enable_o[g] = en[EN_PP];
			assign open_drain_nmos_enable_o[g] = en[EN_ODN];
			assign open_drain_pmos_enable_o[g] = en[EN_ODP];
		end
	endgenerate

	gpi_oe_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pin_oe_o[0] && (cfg_r[PIN_MODE_LSB[0] +: 2] != M2_LV || low_voltage_input_enable_o[0]))
		else $error("input-only pin drives or lost low-voltage enable");

	moe_analog_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!matrix_o[PIN_OE_IDX[5]] && cfg_r[PIN_MODE_LSB[5] +: 2] == M2_HIGH) |-> analog_path_enable_o[5])
		else $error("matrix-oe pin missed analog mode");

	pp_double_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(matrix_o[PIN_OE_IDX[10]] && cfg_r[PIN_OMODE_LSB[10] +: 2] == M2_HYST)
		|-> (push_pull_single_enable_o[10] && push_pull_double_enable_o[10] && pin_oe_o[10]))
		else $error("double push-pull legs not both on");

	quad_nmos_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(matrix_o[PIN_OE_IDX[8]] && cfg_r[PIN_OMODE_LSB[8] + 1]) |-> open_drain_nmos_enable_o[8])
		else $error("quad pin open drain without nmos enable");

	reg_oe_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pin_oe_o[4] == cfg_r[PIN_MODE_LSB[4] + 2] && pin_oe_o[9] == cfg_r[PIN_MODE_LSB[9] + 2])
		else $error("register pin oe not set by mode code");

	reg_ana_odn_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(cfg_r[PIN_MODE_LSB[12] +: 3] == M3_ANA_ODN) |-> (open_drain_nmos_enable_o[12] && analog_path_enable_o[12]))
		else $error("code 111 lacks nmos or analog enable");

	dst_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$stable(cfg_r[SEL_W-1:0]) |-> matrix_o[0] == src_w[cfg_r[SEL_W-1:0]])
		else $error("destination 0 does not follow its selector");

	fixed_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!src_w[0] && src_w[N_SRC-1] && src_w[N_SRC-2] == core_power_on_reset_n)
		else $error("fixed sources miswired");

	virt_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ack_o && we_i && adr_i == ADR_VIRT && sel_i[0]) |-> (virt_r == dat_i[7:0] && src_w[39:34] == dat_i[7:2]))
		else $error("virtual byte write not applied");

	reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ack_o && we_i && adr_i == ADR_RELOAD && sel_i[0] && dat_i[0]) |-> cfg_r == $past(otp_image_i))
		else $error("reload did not copy image");

	prediv_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(cfg_r[PREDIV_LSB +: 2] == 2'h1 && $stable(cfg_r[PREDIV_LSB +: 2]) && osc_fast_i && !osc_q_r)
		|=> src_w[29] != $past(src_w[29]))
		else $error("divide-by-two source did not toggle");
endmodule : routing_matrix

//--- verification/fabric_model.sv
/*
 * fabric_model: stand-in for the pins and macrocells that feed the matrix sources.
 * assumes the bench sets one shared level and toggles the fast oscillator itself.
 */
`timescale 1ns/1ps
module fabric_model (
	input wire logic level_i,
	input wire logic osc_i,
	output logic [15:0] pin_o,
	output logic [1:0] psw_o,
	output logic [15:0] macro_o,
	output logic [2:0] pipe_o,
	output logic [1:0] slow_o,
	output logic fast_o,
	output logic [1:0] filt_o,
	output logic [7:0] asm_o,
	output logic [3:0] cmp_o,
	output logic dly_o
);
	// one level for all but the fast oscillator: a swap inside a group stays hidden, traded for size
	assign pin_o = {16{level_i}};
	assign psw_o = {2{level_i}};
	assign macro_o = {16{level_i}};
	assign pipe_o = {3{level_i}};
	assign slow_o = {2{level_i}};
	assign fast_o = osc_i;
	assign filt_o = {2{level_i}};
	assign asm_o = {8{level_i}};
	assign cmp_o = {4{level_i}};
	assign dly_o = level_i;
endmodule : fabric_model

//--- verification/routing_matrix_tb.sv
/*
 * routing_matrix_tb: self-checking bench for the routing matrix and pin-mode decode.
 * assumes the wishbone map and the chosen configuration bit positions of the package.
 */
`timescale 1ns/1ps
module routing_matrix_tb;
	import routing_pkg::*;
	localparam logic [11:0] REG_T [8] = '{12'h001, 12'h002, 12'h004, 12'h008, 12'h900, 12'hA00, 12'hC00, 12'hA08};
	localparam logic [11:0] SER_T [8] = '{12'h001, 12'h002, 12'h004, 12'h000, 12'h000, 12'hA00, 12'h000, 12'h000};
	localparam logic [11:0] IN_T [4] = '{12'h001, 12'h002, 12'h004, 12'h008};
	localparam logic [11:0] OUT_T [4] = '{12'h810, 12'h830, 12'h840, 12'h8C0};
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc_i = 1'h0;
	logic stb_i = 1'h0;
	logic we_i = 1'h0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [CFG_BITS-1:0] otp_image_i = '0;
	logic lvl = 1'h0;
	logic osc = 1'h0;
	logic core_power_on_reset_n = 1'h1;
	logic [N_PIN-1:0] pin_in_i;
	logic [1:0] power_switch_i;
	logic [15:0] macro_out_i;
	logic [2:0] pipe_stage_i;
	logic [1:0] slow_osc_i;
	logic osc_fast_i;
	logic [1:0] filter_edge_i;
	logic [7:0] asm_out_i;
	logic [3:0] comparator_i;
	logic delay_edge_i;
	logic [31:0] dat_o;
	logic ack_o;
	logic [N_DST-1:0] matrix_o;
	logic [N_PIN-1:0] pin_out_o, pin_oe_o, plain_input_enable_o, hysteresis_input_enable_o;
	logic [N_PIN-1:0] low_voltage_input_enable_o, analog_path_enable_o, push_pull_single_enable_o;
	logic [N_PIN-1:0] push_pull_double_enable_o, open_drain_single_enable_o, open_drain_double_enable_o;
	logic [N_PIN-1:0] push_pull_enable_o, open_drain_nmos_enable_o, open_drain_pmos_enable_o;
	logic [1:0] power_switch_control_o;
	int fail_count = 0;
	int total_checks = 0;
	logic [31:0] q;

	always #20 clk_i = ~clk_i;

	fabric_model model_u (.level_i(lvl), .osc_i(osc), .pin_o(pin_in_i), .psw_o(power_switch_i),
		.macro_o(macro_out_i), .pipe_o(pipe_stage_i), .slow_o(slow_osc_i), .fast_o(osc_fast_i), .filt_o(filter_edge_i),
		.asm_o(asm_out_i), .cmp_o(comparator_i), .dly_o(delay_edge_i));

	routing_matrix dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.otp_image_i, .pin_in_i, .power_switch_i, .macro_out_i, .pipe_stage_i, .slow_osc_i, .osc_fast_i,
		.filter_edge_i, .asm_out_i, .comparator_i, .delay_edge_i, .core_power_on_reset_n, .matrix_o,
		.pin_out_o, .pin_oe_o, .plain_input_enable_o, .hysteresis_input_enable_o, .low_voltage_input_enable_o,
		.analog_path_enable_o, .push_pull_single_enable_o, .push_pull_double_enable_o,
		.open_drain_single_enable_o, .open_drain_double_enable_o, .push_pull_enable_o,
		.open_drain_nmos_enable_o, .open_drain_pmos_enable_o, .power_switch_control_o);

	function automatic logic [11:0] en_of(input int p);
		return {pin_oe_o[p], open_drain_pmos_enable_o[p], open_drain_nmos_enable_o[p], push_pull_enable_o[p],
			open_drain_double_enable_o[p], open_drain_single_enable_o[p], push_pull_double_enable_o[p],
			push_pull_single_enable_o[p], analog_path_enable_o[p], low_voltage_input_enable_o[p],
			hysteresis_input_enable_o[p], plain_input_enable_o[p]};
	endfunction : en_of

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", name, e, g);
			fail_count++;
		end
	endtask : chk

	// request held until ack is sampled high, then one idle cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'h1);
		q = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
	endtask : bus

	task automatic cfg(input int w, input logic [3:0] s, input logic [31:0] d);
		bus(1'h1, ADR_CFG_ADDR, 4'h1, 32'(w));
		bus(1'h1, ADR_CFG_DATA, s, d);
	endtask : cfg

	task automatic t_virtual;
		bus(1'h0, ADR_VIRT, 4'hF, 32'h0);
		chk("virt_init", 32'h000000A5, q);
		bus(1'h1, ADR_VIRT, 4'h1, 32'h3C);
		bus(1'h0, ADR_VIRT, 4'hF, 32'h0);
		chk("virt_wr", 32'h0000003C, q);
		cfg(27, 4'h2, 32'h2300);
		chk("virt_src", 32'h1, 32'(matrix_o[109]));
		bus(1'h0, ADR_CFG_ADDR, 4'hF, 32'h0);
		chk("cfg_idx", 32'h0000001B, q);
		bus(1'h0, ADR_CFG_DATA, 4'hF, 32'h0);
		chk("cfg_word", 32'h00002300, q);
		bus(1'h1, ADR_RELOAD, 4'h1, 32'h1);
		bus(1'h0, ADR_VIRT, 4'hF, 32'h0);
		chk("virt_reload", 32'h000000A5, q);
		// reload cleared the slot too, so point it at source 35 again
		bus(1'h1, ADR_CFG_DATA, 4'h2, 32'h2300);
		chk("virt_src2", 32'h0, 32'(matrix_o[109]));
		bus(1'h0, 8'h14, 4'hF, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("test virtual done");
	endtask : t_virtual

	// all 64 sources through the topmost slot, upper two unused slot bits set
	task automatic t_sweep;
		logic e;
		cfg(0, 4'h1, 32'hFF);
		chk("dst0", 32'h1, 32'(matrix_o[0]));
		cfg(12, 4'h5, 32'h003F003F);
		chk("psw_ctl", 32'h3, 32'(power_switch_control_o));
		// word index still points at slot 48; slot 109 lives in word 27
		bus(1'h1, ADR_CFG_ADDR, 4'h1, 32'h0000001B);
		for (int l = 0; l < 2; l++) begin
			lvl <= l[0];
			core_power_on_reset_n <= ~l[0];
			for (int s = 0; s < N_SRC; s++) begin
				bus(1'h1, ADR_CFG_DATA, 4'h2, (32'(s) | 32'hC0) << 8);
				e = l[0];
				if (s == 0) e = 1'h0;
				if (s == 63) e = 1'h1;
				if (s == 62) e = ~l[0];
				if (s >= 32 && s <= 39) e = 1'(8'hA5 >> (s - 32));
				if (s == 29) e = 1'h0;
				chk($sformatf("src%0d", s), 32'(e), 32'(matrix_o[109]));
			end
		end
		$display("test sweep done");
	endtask : t_sweep

	task automatic t_modes;
		for (int c = 0; c < 8; c++) begin
			lvl <= c[0];
			cfg(32, 4'hF, 32'(c) << 16);
			chk("io2", 32'(REG_T[c]), 32'(en_of(2)));
			cfg(34, 4'hF, 32'(c) << 13);
			chk("io9", 32'(REG_T[c]), 32'(en_of(9)));
			cfg(33, 4'hF, (32'(c) << 21) | (32'(c) << 12));
			chk("io6", 32'(SER_T[c]), 32'(en_of(6)));
			chk("io5", 32'(IN_T[c[1:0]]), 32'(en_of(5)));
			cfg(35, 4'hF, 32'(c) << 5);
			chk("io12", 32'(REG_T[c]), 32'(en_of(12)));
		end
		for (int c = 0; c < 4; c++) begin
			cfg(32, 4'hF, 32'(c) << 8);
			chk("io0", 32'((c == 3) ? 12'h000 : IN_T[c]), 32'(en_of(0)));
		end
		$display("test modes done");
	endtask : t_modes

	// output enables of pins 1 and 8 follow the shared level through source 8
	task automatic t_moe;
		cfg(6, 4'hF, 32'h00083F00);
		cfg(8, 4'hF, 32'h3F000000);
		cfg(9, 4'hF, 32'h3F000008);
		for (int c = 0; c < 4; c++) begin
			lvl <= 1'h0;
			cfg(32, 4'hF, 32'(c) << 10);
			cfg(34, 4'hF, 32'(c) << 4);
			chk("io1_in", 32'(IN_T[c]), 32'(en_of(1)));
			chk("io8_in", 32'(IN_T[c]), 32'(en_of(8)));
			lvl <= 1'h1;
			cfg(32, 4'hF, 32'(c) << 12);
			cfg(34, 4'hF, (32'(c) << 6) | (32'(c) << 22));
			chk("io1_out", 32'(OUT_T[c]), 32'(en_of(1) & 12'hFF0));
			chk("io10_out", 32'(OUT_T[c]), 32'(en_of(10)));
			chk("io8_out", 32'(OUT_T[c] | (c[1] ? 12'h200 : 12'h000)), 32'(en_of(8) & 12'hFF0));
			chk("io_val", 32'h3, 32'({pin_out_o[8], pin_out_o[1]}));
		end
		// pins 1, 8, 10 driven by the matrix, pin 12 by its code 111
		bus(1'h0, ADR_STATUS, 4'hF, 32'h0);
		chk("status", 32'hFFFF1502, q);
		$display("test matrix_oe done");
	endtask : t_moe

	// divide-by-two of the fast oscillator seen through slot 109
	task automatic t_prediv;
		cfg(61, 4'h2, 32'h0100);
		cfg(27, 4'h2, 32'h1D00);
		for (int i = 0; i < 4; i++) begin
			osc <= 1'h1;
			@(posedge clk_i);
			osc <= 1'h0;
			@(posedge clk_i);
			chk("prediv", i[0] ? 32'h0 : 32'h1, 32'(matrix_o[109]));
		end
		$display("test prediv done");
	endtask : t_prediv

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up

	initial begin
		otp_image_i[VIRT_LSB +: 8] = 8'hA5;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		t_virtual();
		t_sweep();
		t_modes();
		t_moe();
		t_prediv();
		wrap_up();
	end

	// whole run is under a thousand cycles
	initial begin
		#(40 * 20000);
		fail_count++;
		wrap_up();
	end
endmodule : routing_matrix_tb
